// ===== shared/ctae_pkg.sv
// constants and types shared by the transfer/arithmetic execution unit
// assumes instructions arrive already decoded from the fetch path
package ctae_pkg;

   typedef enum logic [2:0] {
      OP_MOV,
      OP_XCH,
      OP_WORD_MOVE_OP,
      OP_XCHW,
      OP_ADD,
      OP_ADD_WITH_CARRY_OP,
      OP_SUB
   } ctae_op_e;

   // operand form; to_reg chooses direction where a form can go both ways
   typedef enum logic [3:0] {
      F_IMM,
      F_REG,
      F_SADDR,
      F_SADDR_IMM,
      F_ABS,
      F_IND_DE,
      F_IND_HL,
      F_IND_HLB,
      F_PSW,
      F_PSW_IMM
   } ctae_form_e;

   // absolute register numbers
   localparam logic [2:0] R_X = 3'h0;
   localparam logic [2:0] R_A = 3'h1;
   localparam logic [2:0] R_C = 3'h2;
   localparam logic [2:0] R_B = 3'h3;
   localparam logic [2:0] R_E = 3'h4;
   localparam logic [2:0] R_D = 3'h5;
   localparam logic [2:0] R_L = 3'h6;
   localparam logic [2:0] R_H = 3'h7;

   // pair numbers
   localparam logic [1:0] RP_AX = 2'h0;
   localparam logic [1:0] RP_BC = 2'h1;
   localparam logic [1:0] RP_DE = 2'h2;
   localparam logic [1:0] RP_HL = 2'h3;

   // program status word bit positions
   localparam int unsigned PSW_IE = 7;
   localparam int unsigned PSW_Z  = 6;
   localparam int unsigned PSW_AC = 4;
   localparam int unsigned PSW_CY = 0;

   localparam logic [7:0]  PSW_RESET = 8'h00;
   localparam logic [7:0]  GPR_RESET = 8'h00;

   // short direct window: field 20h..ffh then 00h..1fh maps fe20h..ff1fh
   localparam logic [15:0] SADDR_BASE = 16'hfe20;
   localparam logic [7:0]  SADDR_OFF0 = 8'h20;
   localparam logic [15:0] TABLE_BASE = 16'h0040;

   // cycle counts in cpu clocks, byte lengths
   localparam logic [3:0]  CYC_4 = 4'h4;
   localparam logic [3:0]  CYC_6 = 4'h6;
   localparam logic [3:0]  CYC_8 = 4'h8;
   localparam logic [1:0]  LEN_1 = 2'h1;
   localparam logic [1:0]  LEN_2 = 2'h2;
   localparam logic [1:0]  LEN_3 = 2'h3;

endpackage

// ===== shared/ctae_alu_if.sv
// operand and result bundle between the execution unit and its adder
// assumes the adder is purely combinational
interface ctae_alu_if;
   logic [7:0] a;
   logic [7:0] b;
   logic       cin;
   logic       sub;
   logic [7:0] result;
   logic       carry;
   logic       half;
   logic       zero;

   modport exec (output a, b, cin, sub, input result, carry, half, zero);
   modport alu  (input a, b, cin, sub, output result, carry, half, zero);
endinterface

// ===== design/ctae_alu.sv
// 8-bit add/subtract with carry-in, carry/borrow, nibble carry and zero
// assumes operands are stable within the cycle they are used
module ctae_alu (
   ctae_alu_if.alu alu_port
);

   logic [8:0] full;
   logic [4:0] nib;

   always_comb begin
      if (alu_port.sub) begin
         full = {1'b0, alu_port.a} - {1'b0, alu_port.b} - {8'h00, alu_port.cin};
         nib  = {1'b0, alu_port.a[3:0]} - {1'b0, alu_port.b[3:0]} - {4'h0, alu_port.cin};
      end else begin
         full = {1'b0, alu_port.a} + {1'b0, alu_port.b} + {8'h00, alu_port.cin};
         nib  = {1'b0, alu_port.a[3:0]} + {1'b0, alu_port.b[3:0]} + {4'h0, alu_port.cin};
      end
   end

   // bit 8 is the carry on add and the borrow on subtract
   assign alu_port.result = full[7:0];
   assign alu_port.carry  = full[8];
   assign alu_port.half   = nib[4];
   assign alu_port.zero   = (full[7:0] == 8'h00);

endmodule

// ===== design/ctae_exec.sv
// execution unit for transfer, exchange, word move and add/add_with_carry_op/sub
// assumes a decoded instruction with start_in, a data memory answering a
// read one clock after mem_rd_out, and cpu_clk_en_in from the clock divider
module ctae_exec (
   input  wire logic                 sys_clk_in,
   input  wire logic                 resetn_in,
   input  wire logic                 cpu_clk_en_in,
   input  wire logic                 start_in,
   input  ctae_pkg::ctae_op_e        op_in,
   input  ctae_pkg::ctae_form_e      form_in,
   input  wire logic                 to_reg_in,
   input  wire logic [2:0]           reg_in,
   input  wire logic [1:0]           register_pair_operand_in,
   input  wire logic [7:0]           imm8_in,
   input  wire logic [15:0]          imm16_in,
   input  wire logic [7:0]           saddr_in,
   input  wire logic [15:0]          absolute_address_in,
   input  wire logic [4:0]           table_address_in,
   input  wire logic [7:0]           branch_displacement_in,
   input  wire logic [15:0]          pc_in,
   input  wire logic                 nmi_enter_in,
   input  wire logic                 nmi_exit_in,
   input  wire logic [7:0]           mem_rdata_in,
   output logic                      busy_out,
   output logic                      done_out,
   output logic [1:0]                insn_len_out,
   output logic [7:0]                acc_out,
   output logic [7:0]                program_status_word_out,
   output logic                      nmi_in_service_flag_out,
   output logic [15:0]               table_entry_addr_out,
   output logic [15:0]               branch_target_out,
   output logic [7:0]                bit_mask_out,
   output logic [15:0]               mem_addr_out,
   output logic [7:0]                mem_wdata_out,
   output logic                      mem_rd_out,
   output logic                      mem_wr_out
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [15:0] saddr_addr(input logic [7:0] off);
      saddr_addr = ctae_pkg::SADDR_BASE + {8'h00, 8'(off - ctae_pkg::SADDR_OFF0)};
   endfunction

   function automatic logic is_mem(input ctae_pkg::ctae_form_e f);
      is_mem = (f == ctae_pkg::F_SADDR) || (f == ctae_pkg::F_SADDR_IMM) || (f == ctae_pkg::F_ABS) ||
               (f == ctae_pkg::F_IND_DE) || (f == ctae_pkg::F_IND_HL) || (f == ctae_pkg::F_IND_HLB);
   endfunction

   function automatic logic [3:0] insn_clocks(input ctae_pkg::ctae_op_e o, input ctae_pkg::ctae_form_e f,
                                              input logic tr, input logic [2:0] r);
      logic exchange_op;
      exchange_op = (o == ctae_pkg::OP_XCH);
      unique case (f)
         ctae_pkg::F_IMM:       insn_clocks = (o == ctae_pkg::OP_MOV || o == ctae_pkg::OP_WORD_MOVE_OP) ?
                                              ctae_pkg::CYC_6 : ctae_pkg::CYC_4;
         ctae_pkg::F_REG:       insn_clocks = (o == ctae_pkg::OP_XCHW) ? ctae_pkg::CYC_8 :
                                              (exchange_op && r != ctae_pkg::R_X) ? ctae_pkg::CYC_6 : ctae_pkg::CYC_4;
         ctae_pkg::F_SADDR:     insn_clocks = exchange_op ? ctae_pkg::CYC_6 :
                                              (o == ctae_pkg::OP_WORD_MOVE_OP) ? (tr ? ctae_pkg::CYC_6 : ctae_pkg::CYC_8) :
                                              ctae_pkg::CYC_4;
         ctae_pkg::F_SADDR_IMM: insn_clocks = ctae_pkg::CYC_6;
         ctae_pkg::F_ABS:       insn_clocks = ctae_pkg::CYC_8;
         ctae_pkg::F_PSW:       insn_clocks = ctae_pkg::CYC_4;
         ctae_pkg::F_PSW_IMM:   insn_clocks = ctae_pkg::CYC_6;
         default:               insn_clocks = exchange_op ? ctae_pkg::CYC_8 : ctae_pkg::CYC_6;
      endcase
   endfunction

   function automatic logic [1:0] insn_len(input ctae_pkg::ctae_op_e o, input ctae_pkg::ctae_form_e f,
                                           input logic [2:0] r);
      unique case (f)
         ctae_pkg::F_IMM:       insn_len = (o == ctae_pkg::OP_MOV || o == ctae_pkg::OP_WORD_MOVE_OP) ?
                                           ctae_pkg::LEN_3 : ctae_pkg::LEN_2;
         ctae_pkg::F_REG:       insn_len = (o == ctae_pkg::OP_WORD_MOVE_OP || o == ctae_pkg::OP_XCHW ||
                                           (o == ctae_pkg::OP_XCH && r == ctae_pkg::R_X)) ?
                                           ctae_pkg::LEN_1 : ctae_pkg::LEN_2;
         ctae_pkg::F_SADDR,
         ctae_pkg::F_IND_HLB,
         ctae_pkg::F_PSW:       insn_len = ctae_pkg::LEN_2;
         ctae_pkg::F_IND_DE,
         ctae_pkg::F_IND_HL:    insn_len = ctae_pkg::LEN_1;
         default:               insn_len = ctae_pkg::LEN_3;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef enum logic [2:0] {S_IDLE, S_RD, S_CAP, S_EXEC, S_WR, S_WAIT} ctae_state_e;

   ctae_state_e          state;
   ctae_state_e          next_state;
   logic [7:0]           gpr [8];
   logic [7:0]           next_gpr [8];
   logic [7:0]           program_status_word;
   logic [7:0]           next_psw;
   logic                 nmi_active;
   ctae_pkg::ctae_op_e   op_q;
   ctae_pkg::ctae_form_e form_q;
   logic                 to_reg_q;
   logic [2:0]           reg_q;
   logic [1:0]           pair_q;
   logic [7:0]           imm8_q;
   logic [15:0]          imm16_q;
   logic [15:0]          ea;
   logic [3:0]           need;
   logic [3:0]           cnt;
   logic                 word_q;
   logic                 wr_q;
   logic                 idx;
   logic                 next_idx;
   logic [15:0]          rbuf;
   logic [15:0]          wbuf;
   logic [15:0]          exec_wbuf;
   logic [15:0]          next_wbuf;

   ctae_alu_if alu_bus ();

   ctae_alu u_alu (
      .alu_port (alu_bus.alu)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode of the incoming instruction

   wire        accept   = (state == S_IDLE) && start_in;
   wire        in_word  = (op_in == ctae_pkg::OP_WORD_MOVE_OP);
   wire        in_arith = (op_in == ctae_pkg::OP_ADD) || (op_in == ctae_pkg::OP_ADD_WITH_CARRY_OP) || (op_in == ctae_pkg::OP_SUB);
   wire        in_mem   = is_mem(form_in);
   wire        in_mov   = (op_in == ctae_pkg::OP_MOV) || in_word;
   wire        in_rd    = in_mem && (in_mov ? (to_reg_in && form_in != ctae_pkg::F_SADDR_IMM) : 1'b1);
   wire        in_wr    = in_mem && ((in_mov && (!to_reg_in || form_in == ctae_pkg::F_SADDR_IMM)) ||
                                     op_in == ctae_pkg::OP_XCH || (in_arith && form_in == ctae_pkg::F_SADDR_IMM));
   wire [15:0] de       = {gpr[ctae_pkg::R_D], gpr[ctae_pkg::R_E]};
   wire [15:0] hl       = {gpr[ctae_pkg::R_H], gpr[ctae_pkg::R_L]};
   wire [15:0] raw_ea   = (form_in == ctae_pkg::F_ABS)      ? absolute_address_in :
                          (form_in == ctae_pkg::F_IND_DE)   ? de :
                          (form_in == ctae_pkg::F_IND_HL)   ? hl :
                          (form_in == ctae_pkg::F_IND_HLB)  ? hl + {8'h00, imm8_in} :
                          saddr_addr(saddr_in);
   wire [15:0] in_ea    = in_word ? {raw_ea[15:1], 1'b0} : raw_ea;

   ////////////////////////////////////////////////////////////////////////////
   // sequencing

   always_comb begin
      next_state = state;
      next_idx   = idx;
      unique case (state)
         S_IDLE: begin
            next_idx = 1'b0;
            if (start_in) begin
               next_state = in_rd ? S_RD : S_EXEC;
            end
         end
         S_RD:   next_state = S_CAP;
         S_CAP: begin
            if (word_q && !idx) begin
               next_state = S_RD;
               next_idx   = 1'b1;
            end else begin
               next_state = S_EXEC;
            end
         end
         S_EXEC: begin
            next_idx   = 1'b0;
            next_state = wr_q ? S_WR : S_WAIT;
         end
         S_WR: begin
            if (word_q && !idx) begin
               next_idx = 1'b1;
            end else begin
               next_state = S_WAIT;
            end
         end
         S_WAIT: begin
            if (cnt >= need) begin
               next_state = S_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // execution

   wire [15:0] ax       = {gpr[ctae_pkg::R_A], gpr[ctae_pkg::R_X]};
   wire [15:0] sel_pair = {gpr[{pair_q, 1'b1}], gpr[{pair_q, 1'b0}]};
   wire        q_arith  = (op_q == ctae_pkg::OP_ADD) || (op_q == ctae_pkg::OP_ADD_WITH_CARRY_OP) || (op_q == ctae_pkg::OP_SUB);

   assign alu_bus.a   = (form_q == ctae_pkg::F_SADDR_IMM) ? rbuf[7:0] : gpr[ctae_pkg::R_A];
   assign alu_bus.b   = (form_q == ctae_pkg::F_IMM || form_q == ctae_pkg::F_SADDR_IMM) ? imm8_q :
                        (form_q == ctae_pkg::F_REG) ? gpr[reg_q] : rbuf[7:0];
   assign alu_bus.cin = (op_q == ctae_pkg::OP_ADD_WITH_CARRY_OP) && program_status_word[ctae_pkg::PSW_CY];
   assign alu_bus.sub = (op_q == ctae_pkg::OP_SUB);

   always_comb begin
      next_gpr  = gpr;
      next_psw  = program_status_word;
      exec_wbuf = wbuf;
      unique case (op_q)
         ctae_pkg::OP_MOV: begin
            unique case (form_q)
               ctae_pkg::F_IMM:       next_gpr[reg_q] = imm8_q;
               ctae_pkg::F_REG: begin
                  if (to_reg_q) begin
                     next_gpr[ctae_pkg::R_A] = gpr[reg_q];
                  end else begin
                     next_gpr[reg_q] = gpr[ctae_pkg::R_A];
                  end
               end
               ctae_pkg::F_PSW_IMM:   next_psw = imm8_q;
               ctae_pkg::F_PSW: begin
                  if (to_reg_q) begin
                     next_gpr[ctae_pkg::R_A] = program_status_word;
                  end else begin
                     next_psw = gpr[ctae_pkg::R_A];
                  end
               end
               ctae_pkg::F_SADDR_IMM: exec_wbuf = {8'h00, imm8_q};
               default: begin
                  if (to_reg_q) begin
                     next_gpr[ctae_pkg::R_A] = rbuf[7:0];
                  end else begin
                     exec_wbuf = {8'h00, gpr[ctae_pkg::R_A]};
                  end
               end
            endcase
         end
         ctae_pkg::OP_XCH: begin
            if (form_q == ctae_pkg::F_REG) begin
               next_gpr[reg_q]         = gpr[ctae_pkg::R_A];
               next_gpr[ctae_pkg::R_A] = gpr[reg_q];
            end else begin
               next_gpr[ctae_pkg::R_A] = rbuf[7:0];
               exec_wbuf               = {8'h00, gpr[ctae_pkg::R_A]};
            end
         end
         ctae_pkg::OP_WORD_MOVE_OP: begin
            if (form_q == ctae_pkg::F_IMM) begin
               next_gpr[{pair_q, 1'b1}] = imm16_q[15:8];
               next_gpr[{pair_q, 1'b0}] = imm16_q[7:0];
            end else if (form_q == ctae_pkg::F_REG && !to_reg_q) begin
               next_gpr[{pair_q, 1'b1}] = gpr[ctae_pkg::R_A];
               next_gpr[{pair_q, 1'b0}] = gpr[ctae_pkg::R_X];
            end else if (form_q == ctae_pkg::F_REG) begin
               next_gpr[ctae_pkg::R_A] = sel_pair[15:8];
               next_gpr[ctae_pkg::R_X] = sel_pair[7:0];
            end else if (to_reg_q) begin
               next_gpr[ctae_pkg::R_A] = rbuf[15:8];
               next_gpr[ctae_pkg::R_X] = rbuf[7:0];
            end else begin
               exec_wbuf = ax;
            end
         end
         ctae_pkg::OP_XCHW: begin
            next_gpr[{pair_q, 1'b1}] = gpr[ctae_pkg::R_A];
            next_gpr[{pair_q, 1'b0}] = gpr[ctae_pkg::R_X];
            next_gpr[ctae_pkg::R_A]  = sel_pair[15:8];
            next_gpr[ctae_pkg::R_X]  = sel_pair[7:0];
         end
         default: begin
            next_psw[ctae_pkg::PSW_Z]  = alu_bus.zero;
            next_psw[ctae_pkg::PSW_AC] = alu_bus.half;
            next_psw[ctae_pkg::PSW_CY] = alu_bus.carry;
            if (form_q == ctae_pkg::F_SADDR_IMM) begin
               exec_wbuf = {8'h00, alu_bus.result};
            end else begin
               next_gpr[ctae_pkg::R_A] = alu_bus.result;
            end
         end
      endcase
   end

   wire        exec_now = (state == S_EXEC);
   assign next_wbuf     = exec_now ? exec_wbuf : wbuf;
   wire [7:0]  new_a    = exec_now ? next_gpr[ctae_pkg::R_A] : gpr[ctae_pkg::R_A];
   wire [7:0]  new_psw  = exec_now ? next_psw : program_status_word;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= S_IDLE;
         idx   <= 1'b0;
         cnt   <= 4'h0;
         rbuf  <= 16'h0000;
         wbuf  <= 16'h0000;
         program_status_word   <= ctae_pkg::PSW_RESET;
         nmi_active <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            gpr[i] <= ctae_pkg::GPR_RESET;
         end
      end else begin
         state <= next_state;
         idx   <= next_idx;
         wbuf  <= next_wbuf;
         program_status_word   <= new_psw;
         if (exec_now) begin
            gpr <= next_gpr;
         end
         if (state == S_CAP) begin
            if (idx) begin
               rbuf[15:8] <= mem_rdata_in;
            end else begin
               rbuf[7:0] <= mem_rdata_in;
            end
         end
         if (accept) begin
            cnt <= 4'h0;
         end else if (cpu_clk_en_in && state != S_IDLE && cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
         end
         if (nmi_enter_in) begin
            nmi_active <= 1'b1;
         end else if (nmi_exit_in) begin
            nmi_active <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         op_q    <= ctae_pkg::OP_MOV;
         form_q  <= ctae_pkg::F_IMM;
         to_reg_q <= 1'b0;
         reg_q   <= 3'h0;
         pair_q  <= 2'h0;
         imm8_q  <= 8'h00;
         imm16_q <= 16'h0000;
         ea      <= 16'h0000;
         need    <= 4'h0;
         word_q  <= 1'b0;
         wr_q    <= 1'b0;
      end else if (accept) begin
         op_q    <= op_in;
         form_q  <= form_in;
         to_reg_q <= to_reg_in;
         reg_q   <= reg_in;
         pair_q  <= register_pair_operand_in;
         imm8_q  <= imm8_in;
         imm16_q <= imm16_in;
         ea      <= in_ea;
         need    <= insn_clocks(op_in, form_in, to_reg_in, reg_in);
         word_q  <= in_word;
         wr_q    <= in_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all flopped

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         busy_out                <= 1'b0;
         done_out                <= 1'b0;
         insn_len_out            <= 2'h0;
         acc_out                 <= ctae_pkg::GPR_RESET;
         program_status_word_out <= ctae_pkg::PSW_RESET;
         nmi_in_service_flag_out <= 1'b0;
         table_entry_addr_out    <= 16'h0000;
         branch_target_out       <= 16'h0000;
         bit_mask_out            <= 8'h00;
         mem_addr_out            <= 16'h0000;
         mem_wdata_out           <= 8'h00;
         mem_rd_out              <= 1'b0;
         mem_wr_out              <= 1'b0;
      end else begin
         busy_out                <= (next_state != S_IDLE);
         done_out                <= (state == S_WAIT) && (next_state == S_IDLE);
         acc_out                 <= new_a;
         program_status_word_out <= new_psw;
         nmi_in_service_flag_out <= nmi_enter_in || (nmi_active && !nmi_exit_in);
         mem_rd_out              <= (next_state == S_RD);
         mem_wr_out              <= (next_state == S_WR);
         mem_wdata_out           <= next_idx ? next_wbuf[15:8] : next_wbuf[7:0];
         mem_addr_out            <= accept ? in_ea : {ea[15:1], ea[0] | next_idx};
         if (accept) begin
            insn_len_out <= insn_len(op_in, form_in, reg_in);
            table_entry_addr_out <= ctae_pkg::TABLE_BASE + {10'h000, table_address_in, 1'b0};
            branch_target_out <= pc_in + {{8{branch_displacement_in[7]}}, branch_displacement_in};
            bit_mask_out <= 8'h01 << imm8_in[2:0];
         end
      end
   end

endmodule

// ===== bench/ctae_exec_properties.sv
// port-level assertions for the transfer/arithmetic execution unit
// assumes the driver holds op_in steady until done_out
module ctae_exec_properties (
   input wire logic          sys_clk_in,
   input wire logic          resetn_in,
   input wire logic          start_in,
   input ctae_pkg::ctae_op_e op_in,
   input wire logic [4:0]    table_address_in,
   input wire logic [7:0]    branch_displacement_in,
   input wire logic [15:0]   pc_in,
   input wire logic [7:0]    imm8_in,
   input wire logic          nmi_enter_in,
   input wire logic          busy_out,
   input wire logic          done_out,
   input wire logic [7:0]    program_status_word_out,
   input wire logic          nmi_in_service_flag_out,
   input wire logic [15:0]   table_entry_addr_out,
   input wire logic [15:0]   branch_target_out,
   input wire logic [7:0]    bit_mask_out,
   input wire logic [15:0]   mem_addr_out,
   input wire logic          mem_wr_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_accept; start_in && !busy_out && !done_out; endsequence
   property p_done_pulse; done_out |=> !done_out; endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done held too long");
   property p_busy_end; $fell(busy_out) |-> done_out; endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("busy fell without done");
   property p_min_cycles; s_accept |=> busy_out [*3]; endproperty
   a_min_cycles: assert property (p_min_cycles)
      else $error("instruction too short");
   property p_table; s_accept |=> table_entry_addr_out == 16'h0040 + {10'h000, $past(table_address_in), 1'h0}; endproperty
   a_table: assert property (p_table)
      else $error("table entry address wrong");
   property p_branch; s_accept |=> branch_target_out ==
      $past(pc_in) + {{8{$past(branch_displacement_in[7])}}, $past(branch_displacement_in)}; endproperty
   a_branch: assert property (p_branch)
      else $error("branch target wrong");
   property p_bit; s_accept |=> bit_mask_out == 8'h01 << $past(imm8_in[2:0]); endproperty
   a_bit: assert property (p_bit)
      else $error("bit mask wrong");
   property p_nmi; nmi_enter_in |-> ##[1:2] nmi_in_service_flag_out; endproperty
   a_nmi: assert property (p_nmi)
      else $error("nmi flag not set");
   property p_psw_idle; !busy_out && !$past(busy_out) |-> $stable(program_status_word_out); endproperty
   a_psw_idle: assert property (p_psw_idle)
      else $error("flags moved while idle");
   property p_word_pair; $rose(mem_wr_out) && op_in == ctae_pkg::OP_WORD_MOVE_OP |->
      !mem_addr_out[0] ##1 (mem_wr_out && mem_addr_out == $past(mem_addr_out) + 16'h0001); endproperty
   a_word_pair: assert property (p_word_pair)
      else $error("word write not even low then high");
endmodule
bind ctae_exec ctae_exec_properties u_ctae_exec_properties (.*);

// ===== bench/test_cpu_transfer_arith_exec.sv
// self-checking bench for the transfer/arithmetic execution unit
// assumes a flat byte memory answering one clock after the address
module test_cpu_transfer_arith_exec;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t: %h not %h", $time, g, e); end end
   typedef struct {
      ctae_pkg::ctae_op_e   o;
      ctae_pkg::ctae_form_e f;
      logic                 t;
      logic [2:0]           r;
      logic [7:0]           i, a, p;
      logic [1:0]           l;
   } ctae_row_s;
   logic                 sys_clk_in = 1'h0, resetn_in = 1'h0, cpu_clk_en_in = 1'h0, start_in = 1'h0;
   logic                 to_reg_in = 1'h0, nmi_enter_in = 1'h0, nmi_exit_in = 1'h0, busy_out, done_out;
   logic                 nmi_in_service_flag_out, mem_rd_out, mem_wr_out;
   ctae_pkg::ctae_op_e   op_in = ctae_pkg::OP_MOV;
   ctae_pkg::ctae_form_e form_in = ctae_pkg::F_IMM;
   logic [1:0]           register_pair_operand_in = 2'h0, insn_len_out;
   logic [2:0]           reg_in = 3'h0;
   logic [4:0]           table_address_in = 5'h1f;
   logic [7:0]           imm8_in = 8'h00, saddr_in = 8'h00, branch_displacement_in = 8'h80, mem_rdata_in = 8'h00;
   logic [7:0]           acc_out, program_status_word_out, bit_mask_out, mem_wdata_out, mem [0:65535];
   logic [15:0]          imm16_in = 16'h1234, absolute_address_in = 16'h0000, pc_in = 16'hfff0;
   logic [15:0]          table_entry_addr_out, branch_target_out, mem_addr_out;
   int                   checks = 0, miscompares = 0;
   ctae_row_s            rows [9] = '{
      '{ctae_pkg::OP_MOV, ctae_pkg::F_IMM, 1'h1, ctae_pkg::R_A, 8'hff, 8'hff, 8'h00, 2'h3},
      '{ctae_pkg::OP_ADD, ctae_pkg::F_IMM, 1'h1, ctae_pkg::R_A, 8'h01, 8'h00, 8'h51, 2'h2},
      '{ctae_pkg::OP_ADD_WITH_CARRY_OP, ctae_pkg::F_IMM, 1'h1, ctae_pkg::R_A, 8'h00, 8'h01, 8'h00, 2'h2},
      '{ctae_pkg::OP_SUB, ctae_pkg::F_IMM, 1'h1, ctae_pkg::R_A, 8'h02, 8'hff, 8'h11, 2'h2},
      '{ctae_pkg::OP_MOV, ctae_pkg::F_PSW_IMM, 1'h0, ctae_pkg::R_A, 8'h41, 8'hff, 8'h41, 2'h3},
      '{ctae_pkg::OP_XCH, ctae_pkg::F_REG, 1'h1, ctae_pkg::R_X, 8'h00, 8'h00, 8'h41, 2'h1},
      '{ctae_pkg::OP_WORD_MOVE_OP, ctae_pkg::F_IMM, 1'h1, ctae_pkg::R_B, 8'h00, 8'h00, 8'h41, 2'h3},
      '{ctae_pkg::OP_XCHW, ctae_pkg::F_REG, 1'h1, ctae_pkg::R_B, 8'h00, 8'h12, 8'h41, 2'h1},
      '{ctae_pkg::OP_WORD_MOVE_OP, ctae_pkg::F_REG, 1'h1, ctae_pkg::R_B, 8'h00, 8'h00, 8'h41, 2'h1}};

   ctae_exec u_ctae_exec (.*);
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #20 sys_clk_in = ~sys_clk_in;
   // cpu clock at half rate so cycle counts differ from the data path length
   always @(posedge sys_clk_in) begin
      cpu_clk_en_in <= ~cpu_clk_en_in;
      if (mem_rd_out)
         mem_rdata_in <= mem[mem_addr_out];
      if (mem_wr_out)
         mem[mem_addr_out] <= mem_wdata_out;
   end
   task results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // operands stay put until the next call, as the unit may read them late
   task automatic run(input ctae_pkg::ctae_op_e o, input ctae_pkg::ctae_form_e f, input logic t,
                      input logic [2:0] r, input logic [7:0] i, input logic [7:0] s);
      int n;
      @(posedge sys_clk_in);
      op_in <= o;
      form_in <= f;
      // the pair that holds register r
      register_pair_operand_in <= r[2:1];
      {to_reg_in, reg_in, imm8_in, saddr_in, start_in} <= {t, r, i, s, 1'h1};
      {pc_in, branch_displacement_in} <= {pc_in + 16'h0123, ~branch_displacement_in};
      table_address_in <= table_address_in + 5'h07;
      @(posedge sys_clk_in);
      start_in <= 1'h0;
      n = 0;
      while (done_out !== 1'h1 && n < 80) begin
         @(posedge sys_clk_in);
         #1 n++;
      end
      if (n >= 80) begin
         miscompares++;
         results();
      end
      @(posedge sys_clk_in);
      #1;
   endtask
   initial begin
      mem[16'hff1f] = 8'hf8;
      repeat (5) @(posedge sys_clk_in);
      `CHK({acc_out, program_status_word_out}, 16'h0000)
      resetn_in <= 1'h1;
      foreach (rows[k]) begin
         run(rows[k].o, rows[k].f, rows[k].t, rows[k].r, rows[k].i, 8'h00);
         `CHK({acc_out, program_status_word_out}, {rows[k].a, rows[k].p})
         `CHK(insn_len_out, rows[k].l)
      end
      run(ctae_pkg::OP_ADD, ctae_pkg::F_SADDR_IMM, 1'h0, ctae_pkg::R_A, 8'h10, 8'h1f);
      `CHK({mem[16'hff1f], program_status_word_out}, 16'h0801)
      run(ctae_pkg::OP_WORD_MOVE_OP, ctae_pkg::F_SADDR, 1'h0, ctae_pkg::R_A, 8'h00, 8'h21);
      `CHK({mem[16'hfe21], mem[16'hfe20], program_status_word_out}, 24'h00ff01)
      @(posedge sys_clk_in);
      nmi_enter_in <= 1'h1;
      @(posedge sys_clk_in);
      // set and clear together: set must win
      nmi_exit_in <= 1'h1;
      @(posedge sys_clk_in);
      {nmi_enter_in, nmi_exit_in} <= 2'h1;
      #1 `CHK(nmi_in_service_flag_out, 1'h1)
      repeat (3) @(posedge sys_clk_in);
      #1 `CHK(nmi_in_service_flag_out, 1'h0)
      results();
   end
endmodule
